// >>> src/poc_pkg.sv
/*
 * Constants for the second-channel operational control bank: register
 * indices, field positions, writable masks, mode codes and bus codes.
 * Assumes an AXI4-Lite master with 32-bit data and word-aligned access.
 */
package poc_pkg;

    // ------------------------------------------------------------------
    // Bus, register, step and phase widths
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W  = 16;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned REG_W   = 8;
    localparam int unsigned STEP_W  = 16;
    localparam int unsigned PHASE_W = 24;

    // ------------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] IDX_SYNC_CAL  = 16'h0a40;
    localparam logic [ADDR_W-1:0] IDX_OUT_DIS   = 16'h0a41;
    localparam logic [ADDR_W-1:0] IDX_USER_MODE = 16'h0a42;
    localparam logic [ADDR_W-1:0] IDX_RESETS    = 16'h0a43;
    localparam logic [ADDR_W-1:0] IDX_PHASE     = 16'h0a44;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned B_SOFT_SYNC  = 2;
    localparam int unsigned B_CALIBRATE  = 1;
    localparam int unsigned B_POWER_DOWN = 0;
    localparam int unsigned B_B_DRV_OFF  = 3;
    localparam int unsigned B_A_DRV_OFF  = 2;
    localparam int unsigned B_B_CH_PD    = 1;
    localparam int unsigned B_A_CH_PD    = 0;
    localparam int unsigned F_REF_HI     = 6;
    localparam int unsigned F_REF_LO     = 5;
    localparam int unsigned F_MODE_HI    = 4;
    localparam int unsigned F_MODE_LO    = 2;
    localparam int unsigned B_HOLDOVER   = 1;
    localparam int unsigned B_FREE_RUN   = 0;
    localparam int unsigned B_LF_CLEAR   = 2;
    localparam int unsigned B_HIST_RST   = 1;
    localparam int unsigned B_ASYNC_RST  = 0;
    localparam int unsigned B_PH_RESET   = 2;
    localparam int unsigned B_PH_DEC     = 1;
    localparam int unsigned B_PH_INC     = 0;
    localparam int unsigned PH_CMDS      = 3;

    // ------------------------------------------------------------------
    // Writable masks and reset values
    // ------------------------------------------------------------------
    localparam logic [REG_W-1:0] MASK_SYNC_CAL  = 8'h07;
    localparam logic [REG_W-1:0] MASK_OUT_DIS   = 8'h0f;
    localparam logic [REG_W-1:0] MASK_USER_MODE = 8'h7f;
    localparam logic [REG_W-1:0] MASK_RESETS    = 8'h07;
    localparam logic [REG_W-1:0] MASK_PHASE     = 8'h07;
    localparam logic [REG_W-1:0] RST_VAL        = 8'h00;

    // ------------------------------------------------------------------
    // Switchover mode codes
    // ------------------------------------------------------------------
    localparam logic [2:0] MODE_AUTO_REV    = 3'h0;
    localparam logic [2:0] MODE_AUTO_NONREV = 3'h1;
    localparam logic [2:0] MODE_MAN_FB_REF  = 3'h2;
    localparam logic [2:0] MODE_MAN_FB_HOLD = 3'h3;
    localparam logic [2:0] MODE_MAN_NO_FB   = 3'h4;

    // ------------------------------------------------------------------
    // AXI response codes
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> src/poc_ctrl_bank.sv
/*
 * Operational control bank of the second clock channel behind an
 * AXI4-Lite slave: sync, calibration, power-down, output disables,
 * reference selection, forced modes, debug resets and phase adjust.
 * Assumes the step size comes from elsewhere as a level input.
 */
`timescale 1ns/10ps

module poc_ctrl_bank
    import poc_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [DATA_W-1:0]   s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic [STEP_W-1:0]   phase_step,
    output logic                     out_sync_stall,
    output logic                     out_sync_start,
    output logic                     out_sync_restart,
    output logic                     analog_loop_ch_one_cal_start,
    output logic                     channel_deep_sleep,
    output logic                     clock_output_one_b_driver_off,
    output logic                     clock_output_one_a_driver_off,
    output logic                     clock_output_one_b_power_down,
    output logic                     clock_output_one_a_power_down,
    output logic [1:0]               manual_ref_sel,
    output logic                     sel_auto_revertive,
    output logic                     sel_auto_nonrevertive,
    output logic                     sel_manual_ref_fallback,
    output logic                     sel_manual_hold_fallback,
    output logic                     sel_manual_no_fallback,
    output logic                     force_holdover,
    output logic                     force_free_run,
    output logic                     loop_filter_clear,
    output logic                     history_reset,
    output logic                     autosync_reset,
    output logic [PHASE_W-1:0]       phase_offset
);

    // ------------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------------
    function automatic logic [ADDR_W-1:0] reg_index(
        input logic [ADDR_W-1:0] addr
    );
        reg_index = {2'h0, addr[ADDR_W-1:2]};
    endfunction

    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] idx;
        idx = reg_index(addr);
        reg_hit = (idx >= IDX_SYNC_CAL) && (idx <= IDX_PHASE);
    endfunction

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [REG_W-1:0]   sync_and_calibration_reg;
    logic [REG_W-1:0]   output_disable_reg;
    logic [REG_W-1:0]   loop_user_mode_reg;
    logic [REG_W-1:0]   loop_reset_controls_reg;
    logic [PH_CMDS-1:0] phase_cmd_reg;
    logic               soft_sync_prev_reg;
    logic               calibrate_prev_reg;
    logic [PHASE_W-1:0] phase_offset_reg;
    logic [PHASE_W-1:0] phase_offset_next;

    // Write channel state
    logic               aw_got_reg;
    logic               w_got_reg;
    logic [ADDR_W-1:0]  aw_addr_reg;
    logic [REG_W-1:0]   w_data_reg;
    logic               w_strb_reg;
    logic               bvalid_reg;
    logic [1:0]         bresp_reg;

    // Read channel state
    logic               rvalid_reg;
    logic [DATA_W-1:0]  rdata_reg;
    logic [1:0]         rresp_reg;

    logic               aw_take;
    logic               w_take;
    logic               wr_fire;
    logic [ADDR_W-1:0]  wr_addr;
    logic [ADDR_W-1:0]  wr_idx;
    logic [REG_W-1:0]   wr_data;
    logic               wr_lane;
    logic               wr_ok;
    logic               ar_take;
    logic [ADDR_W-1:0]  rd_idx;
    logic [REG_W-1:0]   rd_value;

    // ------------------------------------------------------------------
    // Write handshake
    // ------------------------------------------------------------------
    // Address and data are taken in either order; no new write is
    // accepted until the response has been taken.
    assign s_axi_awready = !aw_got_reg && !bvalid_reg;
    assign s_axi_wready  = !w_got_reg && !bvalid_reg;
    assign aw_take       = s_axi_awvalid && s_axi_awready;
    assign w_take        = s_axi_wvalid && s_axi_wready;
    assign wr_fire       = (aw_got_reg || aw_take) && (w_got_reg || w_take);
    assign wr_addr       = aw_got_reg ? aw_addr_reg : s_axi_awaddr;
    assign wr_data       = w_got_reg ? w_data_reg : s_axi_wdata[REG_W-1:0];
    assign wr_lane       = w_got_reg ? w_strb_reg : s_axi_wstrb[0];
    assign wr_idx        = reg_index(wr_addr);
    assign wr_ok         = wr_fire && wr_lane && reg_hit(wr_addr);

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            aw_got_reg  <= 1'b0;
            aw_addr_reg <= '0;
        end
        else if (wr_fire)
            aw_got_reg <= 1'b0;
        else if (aw_take)
        begin
            aw_got_reg  <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            w_got_reg  <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= 1'b0;
        end
        else if (wr_fire)
            w_got_reg <= 1'b0;
        else if (w_take)
        begin
            w_got_reg  <= 1'b1;
            w_data_reg <= s_axi_wdata[REG_W-1:0];
            w_strb_reg <= s_axi_wstrb[0];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= reg_hit(wr_addr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_reg <= 1'b0;
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    // Calibrate is plain storage, so a retrigger needs a zero first.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            sync_and_calibration_reg <= RST_VAL;
        else if (wr_ok && (wr_idx == IDX_SYNC_CAL))
            sync_and_calibration_reg <= wr_data & MASK_SYNC_CAL;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            output_disable_reg <= RST_VAL;
        else if (wr_ok && (wr_idx == IDX_OUT_DIS))
            output_disable_reg <= wr_data & MASK_OUT_DIS;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            loop_user_mode_reg <= RST_VAL;
        else if (wr_ok && (wr_idx == IDX_USER_MODE))
            loop_user_mode_reg <= wr_data & MASK_USER_MODE;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            loop_reset_controls_reg <= RST_VAL;
        else if (wr_ok && (wr_idx == IDX_RESETS))
            loop_reset_controls_reg <= wr_data & MASK_RESETS;
    end

    // ------------------------------------------------------------------
    // Self-clearing phase commands
    // ------------------------------------------------------------------
    // A bit lives one cycle, in which it is applied; a new write in that
    // cycle wins over the clear and counts as another command.
    generate
        for (genvar i = 0; i < PH_CMDS; i++)
        begin : g_phase_cmd
            always_ff @(posedge ref_clk)
            begin
                if (rst)
                    phase_cmd_reg[i] <= 1'b0;
                else if (wr_ok && (wr_idx == IDX_PHASE) && wr_data[i])
                    phase_cmd_reg[i] <= 1'b1;
                else
                    phase_cmd_reg[i] <= 1'b0;
            end
        end
    endgenerate

    // Reset beats any step; increment and decrement together cancel.
    always_comb
    begin
        phase_offset_next = phase_offset_reg;
        if (phase_cmd_reg[B_PH_RESET])
            phase_offset_next = '0;
        else if (phase_cmd_reg[B_PH_DEC] && !phase_cmd_reg[B_PH_INC])
        begin
            phase_offset_next = phase_offset_reg
                              - PHASE_W'(phase_step);
        end
        else if (phase_cmd_reg[B_PH_INC] && !phase_cmd_reg[B_PH_DEC])
        begin
            phase_offset_next = phase_offset_reg
                              + PHASE_W'(phase_step);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            phase_offset_reg <= '0;
        else
            phase_offset_reg <= phase_offset_next;
    end

    assign phase_offset = phase_offset_reg;

    // ------------------------------------------------------------------
    // Edge events
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            soft_sync_prev_reg           <= 1'b0;
            calibrate_prev_reg           <= 1'b0;
            out_sync_start               <= 1'b0;
            out_sync_restart             <= 1'b0;
            analog_loop_ch_one_cal_start <= 1'b0;
        end
        else
        begin
            soft_sync_prev_reg <= sync_and_calibration_reg[B_SOFT_SYNC];
            calibrate_prev_reg <= sync_and_calibration_reg[B_CALIBRATE];
            out_sync_start <= sync_and_calibration_reg[B_SOFT_SYNC]
                           && !soft_sync_prev_reg;
            out_sync_restart <= !sync_and_calibration_reg[B_SOFT_SYNC]
                             && soft_sync_prev_reg;
            analog_loop_ch_one_cal_start <=
                sync_and_calibration_reg[B_CALIBRATE]
                && !calibrate_prev_reg;
        end
    end

    // ------------------------------------------------------------------
    // Level controls
    // ------------------------------------------------------------------
    // Decoded mode strobes are registered, so they lag the field by one.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            sel_auto_revertive       <= 1'b0;
            sel_auto_nonrevertive    <= 1'b0;
            sel_manual_ref_fallback  <= 1'b0;
            sel_manual_hold_fallback <= 1'b0;
            sel_manual_no_fallback   <= 1'b0;
        end
        else
        begin
            sel_auto_revertive <= loop_user_mode_reg[F_MODE_HI:F_MODE_LO]
                               == MODE_AUTO_REV;
            sel_auto_nonrevertive <= loop_user_mode_reg[F_MODE_HI:F_MODE_LO]
                                  == MODE_AUTO_NONREV;
            sel_manual_ref_fallback <= loop_user_mode_reg[F_MODE_HI:F_MODE_LO]
                                    == MODE_MAN_FB_REF;
            sel_manual_hold_fallback <=
                loop_user_mode_reg[F_MODE_HI:F_MODE_LO]
                == MODE_MAN_FB_HOLD;
            sel_manual_no_fallback <= loop_user_mode_reg[F_MODE_HI:F_MODE_LO]
                                   == MODE_MAN_NO_FB;
        end
    end

    assign out_sync_stall      = sync_and_calibration_reg[B_SOFT_SYNC];
    assign channel_deep_sleep = sync_and_calibration_reg[B_POWER_DOWN];
    assign clock_output_one_b_driver_off =
        output_disable_reg[B_B_DRV_OFF];
    assign clock_output_one_a_driver_off =
        output_disable_reg[B_A_DRV_OFF];
    assign clock_output_one_b_power_down =
        output_disable_reg[B_B_CH_PD];
    assign clock_output_one_a_power_down =
        output_disable_reg[B_A_CH_PD];
    assign manual_ref_sel    = loop_user_mode_reg[F_REF_HI:F_REF_LO];
    assign force_holdover    = loop_user_mode_reg[B_HOLDOVER];
    assign force_free_run    = loop_user_mode_reg[B_FREE_RUN];
    assign loop_filter_clear = loop_reset_controls_reg[B_LF_CLEAR];
    assign history_reset     = loop_reset_controls_reg[B_HIST_RST];
    assign autosync_reset    = loop_reset_controls_reg[B_ASYNC_RST];

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    assign s_axi_arready = !rvalid_reg;
    assign ar_take       = s_axi_arvalid && s_axi_arready;
    assign rd_idx        = reg_index(s_axi_araddr);

    always_comb
    begin
        rd_value = '0;
        case (rd_idx)
            IDX_SYNC_CAL:  rd_value = sync_and_calibration_reg;
            IDX_OUT_DIS:   rd_value = output_disable_reg;
            IDX_USER_MODE: rd_value = loop_user_mode_reg;
            IDX_RESETS:    rd_value = loop_reset_controls_reg;
            IDX_PHASE:     rd_value = {5'h00, phase_cmd_reg};
            default:       rd_value = '0;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= {24'h000000, rd_value};
            rresp_reg  <= reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata  = rdata_reg;
    assign s_axi_rresp  = rresp_reg;

endmodule

// >>> tb/poc_ctrl_bank_checker.sv
/* Assertions on the ports of the control bank.
   Assumes a synchronous active-high reset on ref_clk. */
`timescale 1ns/10ps
module poc_ctrl_bank_checker
    import poc_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              rst,
    input wire logic              s_axi_bvalid,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_rvalid,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic              out_sync_stall,
    input wire logic              out_sync_start,
    input wire logic              out_sync_restart,
    input wire logic              analog_loop_ch_one_cal_start,
    input wire logic              sel_auto_revertive,
    input wire logic              sel_auto_nonrevertive,
    input wire logic              sel_manual_ref_fallback,
    input wire logic              sel_manual_hold_fallback,
    input wire logic              sel_manual_no_fallback,
    input wire logic [PHASE_W-1:0] phase_offset
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_SYNC_START: assert property ($rose(out_sync_stall) |=>
        out_sync_start) else $error("sync start missing");
    AST_SYNC_ONCE: assert property (out_sync_start |=>
        !out_sync_start) else $error("sync start too long");
    AST_RESTART: assert property ($fell(out_sync_stall) |=>
        out_sync_restart && !out_sync_stall) else $error("no restart");
    AST_CAL_ONCE: assert property (analog_loop_ch_one_cal_start |=>
        !analog_loop_ch_one_cal_start) else $error("cal pulse too long");
    AST_CAL_CAUSE: assert property (analog_loop_ch_one_cal_start |->
        $past(s_axi_bvalid)) else $error("cal without write");
    AST_MODE_ONEHOT: assert property ($onehot0({sel_auto_revertive,
        sel_auto_nonrevertive, sel_manual_ref_fallback,
        sel_manual_hold_fallback, sel_manual_no_fallback}))
        else $error("mode select not one-hot");
    AST_RSVD_ZERO: assert property (s_axi_rvalid |->
        s_axi_rdata[31:8] == 24'h000000) else $error("upper rdata set");
    AST_PHASE_CAUSE: assert property ($changed(phase_offset) |->
        $past(s_axi_bvalid)) else $error("phase moved without write");
    cover property (out_sync_start);
    cover property (analog_loop_ch_one_cal_start);
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

// >>> tb/tb_top.sv
/* Self-checking bench for the control bank over AXI4-Lite.
   Assumes the bank answers each request within a few cycles. */
`timescale 1ns/10ps
module tb_top
    import poc_pkg::*;
;
    logic ref_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, manual_ref_sel, r;
    logic [STEP_W-1:0] phase_step;
    logic [PHASE_W-1:0] phase_offset;
    logic out_sync_stall, out_sync_start, out_sync_restart;
    logic analog_loop_ch_one_cal_start, channel_deep_sleep;
    logic clock_output_one_b_driver_off, clock_output_one_a_driver_off;
    logic clock_output_one_b_power_down, clock_output_one_a_power_down;
    logic sel_auto_revertive, sel_auto_nonrevertive;
    logic sel_manual_ref_fallback, sel_manual_hold_fallback;
    logic sel_manual_no_fallback, force_holdover, force_free_run;
    logic loop_filter_clear, history_reset, autosync_reset;
    logic [7:0] d;
    int n_mismatch, n_tests, n_st, n_rs, n_cal;
    localparam logic [7:0] PC [6] = '{8'h01, 8'h01, 8'h02, 8'h02,
                                      8'h02, 8'h04};
    localparam logic [23:0] PE [6] = '{24'h10, 24'h20, 24'h10, 24'h0,
                                       24'hfffff0, 24'h0};
    poc_ctrl_bank i_poc_ctrl_bank (.*);
    initial
    begin
        ref_clk = 0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        n_st += out_sync_start;
        n_rs += out_sync_restart;
        n_cal += analog_loop_ch_one_cal_start;
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wr(input logic [15:0] i, input logic [7:0] v, input logic [3:0] s);
        s_axi_awaddr <= {i[13:0], 2'b00};
        s_axi_wdata <= {24'h0, v};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 0;
        repeat (2) @(posedge ref_clk);
    endtask
    task rd(input logic [15:0] i);
        s_axi_araddr <= {i[13:0], 2'b00};
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata[7:0];
        r = s_axi_rresp;
        s_axi_rready <= 0;
        @(posedge ref_clk);
    endtask
    task t_sync_cal;
        wr(IDX_SYNC_CAL, 8'hfc, 4'h1);
        chk({out_sync_stall, n_st[7:0], n_cal[7:0]}, 17'h10100);
        wr(IDX_SYNC_CAL, 8'h04, 4'h1);
        chk({n_st[7:0], n_rs[7:0]}, 16'h0100);
        wr(IDX_SYNC_CAL, 8'h03, 4'h1);
        chk({out_sync_stall, n_rs[7:0], n_cal[7:0], channel_deep_sleep},
            18'h00203);
        wr(IDX_SYNC_CAL, 8'h02, 4'h1);
        rd(IDX_SYNC_CAL);
        chk({d, n_cal[7:0], channel_deep_sleep}, 17'h00402);
        wr(IDX_SYNC_CAL, 8'h00, 4'h1);
        wr(IDX_SYNC_CAL, 8'h02, 4'h1);
        chk(n_cal, 32'h2);
    endtask
    task t_out_dis;
        for (int b = 0; b < 4; b++)
        begin
            wr(IDX_OUT_DIS, 8'hf0 | (8'h1 << b), 4'h1);
            chk({clock_output_one_b_driver_off, clock_output_one_a_driver_off,
                 clock_output_one_b_power_down, clock_output_one_a_power_down},
                4'h1 << b);
            rd(IDX_OUT_DIS);
            chk(d, 8'h1 << b);
        end
    endtask
    task t_mode;
        for (int m = 0; m < 8; m++)
        begin
            wr(IDX_USER_MODE, 8'h80 | (m % 4) << 5 | m << 2 | (m % 4), 4'h1);
            @(posedge ref_clk);
            chk({sel_auto_revertive, sel_auto_nonrevertive,
                 sel_manual_ref_fallback, sel_manual_hold_fallback,
                 sel_manual_no_fallback},
                m < 5 ? 5'h10 >> m : 5'h00);
            chk({manual_ref_sel, force_holdover, force_free_run},
                (m % 4) * 5);
        end
    endtask
    task t_resets_phase;
        wr(IDX_RESETS, 8'hff, 4'h1);
        rd(IDX_RESETS);
        chk({d, loop_filter_clear, history_reset, autosync_reset},
            11'h3f);
        phase_step <= 16'h0010;
        for (int k = 0; k < 6; k++)
        begin
            wr(IDX_PHASE, PC[k], 4'h1);
            chk(phase_offset, PE[k]);
            rd(IDX_PHASE);
            chk(d, 0);
        end
    endtask
    task t_bad;
        wr(IDX_PHASE + 16'h1, 8'h01, 4'h1);
        chk(r, RESP_SLVERR);
        rd(IDX_PHASE + 16'h1);
        chk({r, d}, {RESP_SLVERR, 8'h0});
        wr(IDX_OUT_DIS, 8'h0f, 4'h0);
        chk({r, clock_output_one_a_power_down}, {RESP_OKAY, 1'b0});
    endtask
    task tally_and_finish;
        if (n_mismatch == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h8;
        {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, phase_step} = 0;
        repeat (4) @(posedge ref_clk);
        rst <= 0;
        @(posedge ref_clk);
        @(posedge ref_clk);
        chk({sel_auto_revertive, channel_deep_sleep, phase_offset},
            26'h2000000);
        for (int i = 0; i < 5; i++)
        begin
            rd(IDX_SYNC_CAL + i[15:0]);
            chk({r, d}, 10'h0);
        end
        t_sync_cal();
        t_out_dis();
        t_mode();
        t_resets_phase();
        t_bad();
        tally_and_finish();
    end
    initial
    begin
        #100000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule
bind poc_ctrl_bank poc_ctrl_bank_checker i_poc_ctrl_bank_checker (.*);
